/* File: flash_rd_pkg.sv */
// Constants, states and carriers of the multi-I/O read front end
package flash_rd_pkg;

    // ----------------------------------------
    // Command codes
    // ----------------------------------------
    localparam logic [7:0] CMD_DUAL_DTR   = 8'hBD;
    localparam logic [7:0] CMD_QUAD_OUT   = 8'h6B;
    localparam logic [7:0] CMD_QUAD_IO    = 8'hEB;
    localparam logic [7:0] CMD_SET_WRAP   = 8'h77;
    localparam logic [7:0] CMD_CONT_RESET = 8'hFF;

    // ----------------------------------------
    // Frame layout
    // ----------------------------------------
    localparam logic [5:0] CMD_BITS   = 6'h08;
    localparam logic [5:0] ADDR_BITS  = 6'h18;
    localparam logic [5:0] MODE_BITS  = 6'h08;
    localparam logic [5:0] WRAP_BITS  = 6'h20;
    localparam logic [2:0] LANE1      = 3'h1;
    localparam logic [2:0] LANE2      = 3'h2;
    localparam logic [2:0] LANE4      = 3'h4;
    localparam logic [1:0] CONT_SEL   = 2'h2;
    localparam int         CONT_LSB   = 4;
    localparam int         WRAP_LSB   = 4;
    localparam logic [1:0] SLOT_LAST2 = 2'h1;
    localparam logic [1:0] SLOT_LAST4 = 2'h3;
    localparam logic [3:0] OE_DUAL    = 4'h3;
    localparam logic [3:0] OE_QUAD    = 4'hF;

    // ----------------------------------------
    // Dummy clock counts
    // ----------------------------------------
    localparam logic [5:0] DUMMY_DUAL     = 6'h04;
    localparam logic [5:0] DUMMY_QUAD_OUT = 6'h08;
    localparam logic [5:0] DUMMY_QIO_DC0  = 6'h04;
    localparam logic [5:0] DUMMY_QIO_DC1  = 6'h06;
    localparam logic [5:0] DUMMY_QPI_P0   = 6'h04;
    localparam logic [5:0] DUMMY_QPI_P1   = 6'h06;
    localparam logic [5:0] DUMMY_QPI_P2   = 6'h08;
    localparam logic [5:0] DUMMY_QPI_P3   = 6'h0A;
    localparam logic [5:0] QPI_MODE_CLKS  = 6'h02;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CMD   = 3'b001,
        ST_ADDR  = 3'b010,
        ST_MODE  = 3'b011,
        ST_DUMMY = 3'b100,
        ST_DATA  = 3'b101,
        ST_WRAP  = 3'b110,
        ST_SKIP  = 3'b111
    } rd_state_e;

    typedef struct packed {
        logic       sclk;
        logic       cs_n;
        logic [3:0] io;
    } pin_s;

    typedef struct packed {
        logic [1:0] len;
        logic       dis;
    } wrap_s;

    localparam wrap_s WRAP_RESET = 3'h1;

endpackage : flash_rd_pkg

/* File: serial_flash_multi_io_read.sv */
// Multi-I/O read command front end of a serial NOR flash
`timescale 1ns/100ps
// Notes on behaviour
// R1: Dual double-rate read takes 24 address bits two per clock on lines 0-1.
// R2: Dual read mode byte bits 5:4 = 10 lets next read skip command byte.
// R3: Any other mode value means next transaction starts with a command byte.
// R4: Host leaves dual continuous mode by sending ones on line 0 for 16 clocks.
// R5: Host sets quad enable before quad-output read.
// R6: Quad-output read: command, address serial, 8 dummies, data on four lines.
// R7: Quad-output read drives four data bits per clock.
// R8: Reads start anywhere, increment per byte, roll over, end at select high.
// R9: Quad reads are refused while a write cycle is busy.
// R10: Host sets quad enable before quad-I/O read.
// R11: Quad-I/O read: address, 2 mode clocks, dummies, data, all four lines.
// R12: Host drives the lines during the mode clocks.
// R13: Serial mode quad-I/O dummy count follows the dummy cycle select bit.
// R14: Four-line mode dummy count comes from the two-bit read parameter.
// R15: Four-line mode counts mode clocks inside the dummy clocks.
// R16: No wrapping for quad-I/O reads in four-line mode.
// R17: Quad-I/O mode bits 10 let the next read skip its command byte.
// R18: A reset command clears continuous mode.
// R19: Host not using continuous read sends mode bits other than 10.
// R20: Wrap setup is command, 24 dummy bits, wrap byte, then select high.
// R21: Wrap disable 0 wraps 8/16/32/64 bytes by length select; 1 is off.
// R22: Wrap setting holds for later quad-I/O reads until a new wrap setup.
// R23: Host rewrites wrap setup with disable bit set to leave wrapping.
// R24: Quad enable flag is status bit nine.
// R25: Wrapping keeps upper address bits, counts only inside the section.
// R26: Continuation uses only mode bits 5:4 of the current read.
module serial_flash_multi_io_read
    import flash_rd_pkg::*;
#(
    parameter int ADDR_W = 24
)(
    input  wire logic              i_sys_clk,
    input  wire logic              i_rstn,
    input  wire logic              i_ce,
    input  wire logic              i_sclk,
    input  wire logic              i_cs_n,
    input  wire logic [3:0]        i_io,
    output logic      [3:0]        o_io,
    output logic      [3:0]        o_io_oe,
    input  wire logic              i_status_bit_nine,
    input  wire logic              i_write_busy,
    input  wire logic              i_four_line_command_mode,
    input  wire logic              i_dummy_cycle_select,
    input  wire logic [1:0]        i_read_param_dummy,
    output logic      [ADDR_W-1:0] o_mem_addr,
    input  wire logic [7:0]        i_mem_data,
    output logic                   o_continuous_mode,
    output wrap_s                  o_wrap_setting
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [23:0] take_in(logic [23:0] s, logic [3:0] io,
                                           logic [2:0] ln);
        unique case (ln)
            LANE4:   take_in = {s[19:0], io};
            LANE2:   take_in = {s[21:0], io[1:0]};
            default: take_in = {s[22:0], io[0]};
        endcase
    endfunction : take_in

    function automatic logic [5:0] clocks_for(logic [5:0] bits, logic [2:0] ln);
        unique case (ln)
            LANE4:   clocks_for = {2'h0, bits[5:2]};
            LANE2:   clocks_for = {1'h0, bits[5:1]};
            default: clocks_for = bits;
        endcase
    endfunction : clocks_for

    function automatic logic [ADDR_W-1:0] wrap_mask(logic [1:0] len);
        wrap_mask = ADDR_W'(({3'h0, 5'h08} << len) - 8'h01); // [R21]
    endfunction : wrap_mask

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    pin_s s1_q, s2_q, s3_q;

    always_ff @(posedge i_sys_clk or negedge i_rstn)
        if (!i_rstn)
        begin
            s1_q <= '{sclk: 1'b0, cs_n: 1'b1, io: 4'h0};
            s2_q <= '{sclk: 1'b0, cs_n: 1'b1, io: 4'h0};
            s3_q <= '{sclk: 1'b0, cs_n: 1'b1, io: 4'h0};
        end
        else if (i_ce)
        begin
            s1_q <= '{sclk: i_sclk, cs_n: i_cs_n, io: i_io};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end

    logic rise, fall, cs_start, cs_end;
    assign rise     = i_ce & s2_q.sclk & ~s3_q.sclk & ~s2_q.cs_n;
    assign fall     = i_ce & ~s2_q.sclk & s3_q.sclk & ~s2_q.cs_n;
    assign cs_start = i_ce & ~s2_q.cs_n & s3_q.cs_n;
    assign cs_end   = i_ce & s2_q.cs_n & ~s3_q.cs_n;

    // ----------------------------------------
    // Phase decode
    // ----------------------------------------
    rd_state_e        st_q;
    logic [7:0]       cmd_q, cont_cmd_q;
    logic [5:0]       cnt_q;
    logic [23:0]      shin_q;
    logic [7:0]       sh_out_q;
    logic [1:0]       slot_q;
    logic             qpi_q, cont_q, wrap_ok_q;
    logic [ADDR_W-1:0] addr_q;
    wrap_s            wrap_q;

    logic [2:0]  in_lanes, addr_lanes, out_lanes;
    logic [5:0]  ph_len, qio_dummy;
    logic        last, wrap_act;
    logic [23:0] took;
    logic [7:0]  new_cmd;
    logic        quad_cmd, refuse;

    always_comb
    begin
        unique case (cmd_q)
            CMD_DUAL_DTR: addr_lanes = LANE2;                              // [R1]
            CMD_QUAD_IO:  addr_lanes = LANE4;                              // [R11]
            default:      addr_lanes = qpi_q ? LANE4 : LANE1;              // [R6]
        endcase
        out_lanes = (cmd_q == CMD_DUAL_DTR) ? LANE2 : LANE4;               // [R7]
    end

    always_comb
    begin
        if (qpi_q)
        begin
            unique case (i_read_param_dummy)                               // [R14]
                2'h0: qio_dummy = DUMMY_QPI_P0 - QPI_MODE_CLKS;           // [R15]
                2'h1: qio_dummy = DUMMY_QPI_P1 - QPI_MODE_CLKS;
                2'h2: qio_dummy = DUMMY_QPI_P2 - QPI_MODE_CLKS;
                2'h3: qio_dummy = DUMMY_QPI_P3 - QPI_MODE_CLKS;
            endcase
        end
        else
        begin
            qio_dummy = i_dummy_cycle_select ? DUMMY_QIO_DC1 : DUMMY_QIO_DC0; // [R13]
        end
    end

    always_comb
    begin
        in_lanes = qpi_q ? LANE4 : LANE1;
        ph_len   = clocks_for(CMD_BITS, in_lanes);
        unique case (st_q)
            ST_ADDR:
            begin
                in_lanes = addr_lanes;
                ph_len   = clocks_for(ADDR_BITS, addr_lanes);
            end
            ST_MODE:
            begin
                in_lanes = addr_lanes;
                ph_len   = clocks_for(MODE_BITS, addr_lanes);
            end
            ST_DUMMY:
            begin
                unique case (cmd_q)
                    CMD_DUAL_DTR: ph_len = DUMMY_DUAL;
                    CMD_QUAD_IO:  ph_len = qio_dummy;
                    default:      ph_len = DUMMY_QUAD_OUT;                 // [R6]
                endcase
            end
            ST_WRAP: ph_len = clocks_for(WRAP_BITS, in_lanes);             // [R20]
            default: ph_len = clocks_for(CMD_BITS, in_lanes);
        endcase
    end

    assign last     = (cnt_q == ph_len - 6'h01);
    assign took     = take_in(shin_q, s2_q.io, in_lanes);
    assign new_cmd  = took[7:0];
    assign quad_cmd = (new_cmd == CMD_QUAD_OUT) || (new_cmd == CMD_QUAD_IO);
    assign refuse   = i_write_busy | ~i_status_bit_nine;                   // [R24]
    assign wrap_act = (cmd_q == CMD_QUAD_IO) & ~qpi_q & ~wrap_q.dis;       // [R16]

    // ----------------------------------------
    // Command sequencer
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rstn)
        if (!i_rstn)
        begin
            st_q   <= ST_IDLE;
            cmd_q  <= 8'h00;
            cnt_q  <= 6'h00;
            shin_q <= 24'h00_0000;
            qpi_q  <= 1'b0;
        end
        else if (cs_end)
        begin
            st_q <= ST_IDLE;
        end
        else if (cs_start)
        begin
            cnt_q <= 6'h00;
            qpi_q <= i_four_line_command_mode;
            // Resumed reads, dual as well as quad, are refused while busy
            if (cont_q)
            begin
                cmd_q <= cont_cmd_q;
                st_q  <= i_write_busy ? ST_SKIP : ST_ADDR;                 // [R2] [R17] [R9]
            end
            else
            begin
                st_q <= ST_CMD;                                            // [R3]
            end
        end
        else if (rise && st_q != ST_IDLE && st_q != ST_DATA && st_q != ST_SKIP)
        begin
            shin_q <= took;
            cnt_q  <= last ? 6'h00 : cnt_q + 6'h01;
            if (last)
            begin
                unique case (st_q)
                    ST_CMD:
                    begin
                        cmd_q <= new_cmd;
                        if (new_cmd == CMD_DUAL_DTR)
                            st_q <= ST_ADDR;
                        else if (quad_cmd)
                            st_q <= refuse ? ST_SKIP : ST_ADDR;            // [R9]
                        else if (new_cmd == CMD_SET_WRAP)
                            st_q <= ST_WRAP;
                        else
                            st_q <= ST_SKIP;
                    end
                    ST_ADDR:  st_q <= (cmd_q == CMD_QUAD_OUT) ? ST_DUMMY : ST_MODE;
                    ST_MODE:  st_q <= ST_DUMMY;                            // [R11]
                    ST_DUMMY: st_q <= ST_DATA;
                    ST_WRAP:  st_q <= ST_SKIP;
                    default:  st_q <= ST_SKIP;
                endcase
            end
        end

    // ----------------------------------------
    // Continuous mode
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rstn)
        if (!i_rstn)
        begin
            cont_q     <= 1'b0;
            cont_cmd_q <= 8'h00;
        end
        else if (rise && last && st_q == ST_MODE)
        begin
            // Low nibble is don't care
            cont_q     <= (took[CONT_LSB+:2] == CONT_SEL);                 // [R2] [R3] [R17] [R26]
            cont_cmd_q <= cmd_q;
        end
        else if (rise && last && st_q == ST_CMD && new_cmd == CMD_CONT_RESET)
        begin
            cont_q <= 1'b0;                                                // [R18]
        end

    // ----------------------------------------
    // Wrap setup
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rstn)
        if (!i_rstn)
        begin
            wrap_ok_q <= 1'b0;
            wrap_q    <= WRAP_RESET;
        end
        else if (cs_end)
        begin
            wrap_ok_q <= 1'b0;
            // Only a frame ending exactly on the wrap byte counts
            if (wrap_ok_q && st_q == ST_SKIP && cmd_q == CMD_SET_WRAP)
                wrap_q <= shin_q[WRAP_LSB+:3];                             // [R20] [R22]
        end
        else if (rise)
        begin
            wrap_ok_q <= (st_q == ST_WRAP) & last;
        end

    // ----------------------------------------
    // Data out and address counter
    // ----------------------------------------
    logic [ADDR_W-1:0] addr_next;
    logic [7:0]        src;
    logic              byte_end;

    always_comb
    begin
        if (wrap_act)
            addr_next = (addr_q & ~wrap_mask(wrap_q.len))                 // [R25]
                      | ((addr_q + 1'b1) & wrap_mask(wrap_q.len));
        else
            addr_next = addr_q + 1'b1;                                     // [R8]
        src      = (slot_q == 2'h0) ? i_mem_data : sh_out_q;
        byte_end = (out_lanes == LANE2) ? (slot_q == SLOT_LAST4) : (slot_q == SLOT_LAST2);
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
        if (!i_rstn)
        begin
            addr_q   <= '0;
            sh_out_q <= 8'h00;
            slot_q   <= 2'h0;
            o_io     <= 4'h0;
            o_io_oe  <= 4'h0;
        end
        else if (cs_end || cs_start)
        begin
            slot_q  <= 2'h0;
            o_io_oe <= 4'h0;
        end
        else if (rise && last && st_q == ST_ADDR)
        begin
            addr_q <= took[ADDR_W-1:0];
        end
        else if (fall && st_q == ST_DATA)
        begin
            slot_q <= byte_end ? 2'h0 : slot_q + 2'h1;
            if (slot_q == 2'h0)
                addr_q <= addr_next;                                       // [R8] [R22]
            if (out_lanes == LANE2)
            begin
                o_io     <= {2'h0, src[7:6]};
                o_io_oe  <= OE_DUAL;
                sh_out_q <= {src[5:0], 2'h0};
            end
            else
            begin
                o_io     <= src[7:4];                                      // [R7]
                o_io_oe  <= OE_QUAD;
                sh_out_q <= {src[3:0], 4'h0};
            end
        end

    assign o_mem_addr        = addr_q;
    assign o_continuous_mode = cont_q;
    assign o_wrap_setting    = wrap_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_cmd_done;
        rise && st_q == ST_CMD && last && !cs_end && !cs_start;
    endsequence
    sequence s_mode_done;
        rise && st_q == ST_MODE && last && !cs_end && !cs_start;
    endsequence

    property p_busy_refuse;
        s_cmd_done and (quad_cmd && i_write_busy) |=> st_q == ST_SKIP;
    endproperty
    a_busy_refuse: assert property (p_busy_refuse) else $error("quad read taken while busy"); // [R9]

    property p_qe_gate;
        s_cmd_done and (quad_cmd && !i_status_bit_nine) |=> st_q == ST_SKIP;
    endproperty
    a_qe_gate: assert property (p_qe_gate) else $error("quad read taken without enable"); // [R24]

    property p_cont_set;
        s_mode_done and (took[5:4] == 2'h2) |=> o_continuous_mode ##0 st_q == ST_DUMMY;
    endproperty
    a_cont_set: assert property (p_cont_set) else $error("continuous mode not entered"); // [R17]

    property p_cont_clear;
        s_mode_done and (took[5:4] != 2'h2) |=> !o_continuous_mode;
    endproperty
    a_cont_clear: assert property (p_cont_clear) else $error("continuous mode kept"); // [R3]

    property p_skip_cmd;
        cs_start && o_continuous_mode && !i_write_busy |=> st_q == ST_ADDR && cmd_q == $past(cont_cmd_q);
    endproperty
    a_skip_cmd: assert property (p_skip_cmd) else $error("command byte not skipped"); // [R2]

    property p_cmd_first;
        cs_start && !o_continuous_mode |=> st_q == ST_CMD;
    endproperty
    a_cmd_first: assert property (p_cmd_first) else $error("command byte expected"); // [R3]

    property p_addr_inc;
        fall && st_q == ST_DATA && slot_q == 2'h0 && !wrap_act && !cs_end && !cs_start
            |=> o_mem_addr == ADDR_W'($past(o_mem_addr) + 1'b1);
    endproperty
    a_addr_inc: assert property (p_addr_inc) else $error("linear address step wrong"); // [R8]

    property p_wrap_bound;
        fall && st_q == ST_DATA && slot_q == 2'h0 && wrap_act && !cs_end && !cs_start
            |=> (o_mem_addr & ~wrap_mask(wrap_q.len)) == $past(o_mem_addr & ~wrap_mask(wrap_q.len));
    endproperty
    a_wrap_bound: assert property (p_wrap_bound) else $error("wrap left its section"); // [R25]

    property p_quad_lanes;
        fall && st_q == ST_DATA && cmd_q == CMD_QUAD_OUT && !cs_end && !cs_start |=> o_io_oe == 4'hF;
    endproperty
    a_quad_lanes: assert property (p_quad_lanes) else $error("quad data not on four lines"); // [R7]

    property p_no_qpi_wrap;
        fall && st_q == ST_DATA && slot_q == 2'h0 && qpi_q && !cs_end && !cs_start
            |=> o_mem_addr == ADDR_W'($past(o_mem_addr) + 1'b1);
    endproperty
    a_no_qpi_wrap: assert property (p_no_qpi_wrap) else $error("wrap active in four-line mode"); // [R16]

endmodule : serial_flash_multi_io_read

/* File: flash_host_model.sv */
// Behavioural serial host driving chip select, serial clock and I/O lines
`timescale 1ns/100ps
module flash_host_model
    import flash_rd_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic [3:0] i_io,
    output pin_s            o_pins,
    output logic      [3:0] o_io_oe
);
    // ----------------------------------------
    // Pin primitives, one serial clock is 8 system clocks
    // ----------------------------------------
    initial
    begin
        o_pins  = pin_s'(6'h10);
        o_io_oe = 4'h0;
    end

    // Sample late in the high phase: device output lags the falling edge
    task automatic clk1(input logic [3:0] v, input logic drive, output logic [3:0] r);
        @(negedge i_sys_clk);
        o_pins.sclk = 1'b0;
        o_pins.io   = v;
        o_io_oe     = drive ? 4'hF : 4'h0;
        repeat (4) @(negedge i_sys_clk);
        o_pins.sclk = 1'b1;
        repeat (3) @(negedge i_sys_clk);
        r = i_io;
    endtask : clk1

    task automatic send(input logic [31:0] v, input int n, input int w);
        logic [3:0]  r;
        logic [31:0] s;
        for (int i = 0; i < n; i++)
        begin
            s = v >> (w * (n - 1 - i));
            clk1(s[3:0] & ((4'h1 << w) - 4'h1), 1'b1, r);
        end
    endtask : send

    task automatic recv(input int n, input int w, output logic [63:0] v);
        logic [3:0] r;
        v = '0;
        for (int i = 0; i < n; i++)
        begin
            clk1(4'h0, 1'b0, r);
            v = (v << w) | 64'(r & ((4'h1 << w) - 4'h1));
        end
    endtask : recv

    task automatic start();
        @(negedge i_sys_clk);
        o_pins.cs_n = 1'b0;
        repeat (4) @(negedge i_sys_clk);
    endtask : start

    // Clock parked low before select rises, as the device expects
    task automatic stop();
        @(negedge i_sys_clk);
        o_pins.sclk = 1'b0;
        o_io_oe     = 4'h0;
        repeat (4) @(negedge i_sys_clk);
        o_pins.cs_n = 1'b1;
        repeat (8) @(negedge i_sys_clk);
    endtask : stop
endmodule : flash_host_model

/* File: serial_flash_multi_io_read_tb.sv */
// Self-checking bench of the multi-I/O read front end
`timescale 1ns/100ps
`define CHK(nm, e, g) \
    begin \
        num_checks++; \
        if ((g) !== (e)) \
        begin \
            err_total++; \
            $display("ERROR %s expected %h seen %h", nm, e, g); \
        end \
    end
module serial_flash_multi_io_read_tb
    import flash_rd_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        rstn    = 1'b0;
    logic        qe_en   = 1'b1;
    logic        busy    = 1'b0;
    logic        ce      = 1'b1;
    logic        four    = 1'b0;
    logic        dc_sel  = 1'b0;
    logic [1:0]  param   = 2'h0;
    logic        wdis    = 1'b1;
    logic [1:0]  wlen    = 2'h0;
    logic [31:0] seed    = 32'h0000_0029;
    logic [3:0]  noise_q = 4'h0;
    int          err_total  = 0;
    int          num_checks = 0;
    pin_s        pins;
    logic [3:0]  host_oe;
    logic [3:0]  dev_io;
    logic [3:0]  dev_oe;
    logic [3:0]  io_wire;
    logic [23:0] mem_addr;
    logic [7:0]  mem_data;
    logic        cont;
    wrap_s       wrap_set;

    always #4 sys_clk = ~sys_clk;
    // Undriven lines wander so a stale value never passes for data
    always_ff @(negedge sys_clk) noise_q <= noise_q + 4'h7;
    assign io_wire  = (dev_io & dev_oe) | (pins.io & host_oe & ~dev_oe) | (noise_q & ~dev_oe & ~host_oe);
    assign mem_data = mem_byte(mem_addr);

    serial_flash_multi_io_read #(
        .ADDR_W (24)
    ) i_dut (
        .i_sys_clk                (sys_clk),
        .i_rstn                   (rstn),
        .i_ce                     (ce),
        .i_sclk                   (pins.sclk),
        .i_cs_n                   (pins.cs_n),
        .i_io                     (io_wire),
        .o_io                     (dev_io),
        .o_io_oe                  (dev_oe),
        .i_status_bit_nine        (qe_en),
        .i_write_busy             (busy),
        .i_four_line_command_mode (four),
        .i_dummy_cycle_select     (dc_sel),
        .i_read_param_dummy       (param),
        .o_mem_addr               (mem_addr),
        .i_mem_data               (mem_data),
        .o_continuous_mode        (cont),
        .o_wrap_setting           (wrap_set)
    );

    flash_host_model i_host (
        .i_sys_clk (sys_clk),
        .i_io      (io_wire),
        .o_pins    (pins),
        .o_io_oe   (host_oe)
    );

    // ----------------------------------------
    // Expectation helpers
    // ----------------------------------------
    function automatic logic [7:0] mem_byte(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'hA5;
    endfunction : mem_byte

    function automatic logic [23:0] nxt(input logic [23:0] a, input int wl);
        logic [23:0] m;
        m = 24'(wl - 1);
        return (wl == 0) ? a + 24'h1 : (a & ~m) | ((a + 24'h1) & m);
    endfunction : nxt

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic rd(input logic [7:0] cmd, input logic skip, input logic [23:0] a, input logic [7:0] m,
                      input int nb, input logic ok);
        int          w;
        int          dm;
        int          wl;
        logic [23:0] e;
        logic [63:0] v;
        w  = (cmd == CMD_DUAL_DTR) ? 2 : 4;
        dm = (cmd == CMD_QUAD_OUT) ? int'(DUMMY_QUAD_OUT) : (cmd == CMD_DUAL_DTR) ? int'(DUMMY_DUAL)
           : four ? 2 * int'(param) + 2 : dc_sel ? int'(DUMMY_QIO_DC1) : int'(DUMMY_QIO_DC0);
        wl = (!four && cmd == CMD_QUAD_IO && !wdis) ? (8 << wlen) : 0;
        e  = a;
        i_host.start();
        if (!skip)
            i_host.send(32'(cmd), four ? 2 : 8, four ? 4 : 1);
        if (cmd == CMD_QUAD_OUT)
            i_host.send(32'(a), 24, 1);
        else
            i_host.send(32'(a), 24 / w, w);
        if (cmd != CMD_QUAD_OUT)
            i_host.send(32'(m), 8 / w, w);
        i_host.send(32'h0000_0000, dm, 1);
        for (int i = 0; i < nb; i++)
        begin
            i_host.recv(8 / w, w, v);
            if (ok)
                `CHK("read byte", mem_byte(e), v[7:0])
            e = nxt(e, wl);
        end
        `CHK("data enable", ok ? ((w == 2) ? OE_DUAL : OE_QUAD) : 4'h0, dev_oe)
        i_host.stop();
    endtask : rd

    task automatic set_wrap(input logic dis, input logic [1:0] len);
        i_host.start();
        i_host.send(32'(CMD_SET_WRAP), 8, 1);
        i_host.send({25'h000_0000, len, dis, 4'h0}, 32, 1);
        i_host.stop();
        wdis = dis;
        wlen = len;
        `CHK("wrap setting", wrap_s'({len, dis}), wrap_set)
    endtask : set_wrap

    task automatic complete_run();
        if (err_total == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        logic [7:0] m;
        repeat (8) @(negedge sys_clk);
        `CHK("reset wrap", WRAP_RESET, wrap_set)
        `CHK("reset enable", 4'h0, dev_oe)
        rstn = 1'b1;
        repeat (2) @(negedge sys_clk);
        rd(CMD_QUAD_OUT, 1'b0, 24'(rnd()), 8'h00, 6, 1'b1);
        rd(CMD_QUAD_OUT, 1'b0, 24'hFF_FFFE, 8'h00, 4, 1'b1);
        busy = 1'b1;
        rd(CMD_QUAD_OUT, 1'b0, 24'h00_0100, 8'h00, 2, 1'b0);
        rd(CMD_QUAD_IO, 1'b0, 24'h00_0100, 8'h00, 2, 1'b0);
        busy  = 1'b0;
        qe_en = 1'b0;
        rd(CMD_QUAD_OUT, 1'b0, 24'h00_0200, 8'h00, 2, 1'b0);
        qe_en = 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            dc_sel = i[0];
            m      = 8'(rnd()) & 8'hCF;
            rd(CMD_QUAD_IO, 1'b0, 24'(rnd()), m, 5, 1'b1);
            `CHK("continuous", 1'b0, cont)
        end
        m = (8'(rnd()) & 8'hCF) | 8'h20;
        rd(CMD_QUAD_IO, 1'b0, 24'(rnd()), m, 3, 1'b1);
        `CHK("continuous", 1'b1, cont)
        rd(CMD_QUAD_IO, 1'b1, 24'(rnd()), 8'h10, 3, 1'b1);
        `CHK("continuous", 1'b0, cont)
        rd(CMD_QUAD_IO, 1'b0, 24'(rnd()), 8'hA5, 2, 1'b1);
        busy = 1'b1;
        rd(CMD_QUAD_IO, 1'b1, 24'(rnd()), 8'h20, 2, 1'b0);
        busy = 1'b0;
        `CHK("continuous", 1'b1, cont)
        i_host.start();
        i_host.send(32'(CMD_CONT_RESET), 8, 1);
        i_host.stop();
        `CHK("continuous", 1'b0, cont)
        rd(CMD_DUAL_DTR, 1'b0, 24'(rnd()), 8'h2F, 4, 1'b1);
        `CHK("continuous", 1'b1, cont)
        rd(CMD_DUAL_DTR, 1'b1, 24'(rnd()), 8'h20, 2, 1'b1);
        i_host.start();
        i_host.send(32'h0000_FFFF, 16, 1);
        i_host.stop();
        `CHK("continuous", 1'b0, cont)
        for (int l = 0; l < 4; l++)
        begin
            set_wrap(1'b0, l[1:0]);
            rd(CMD_QUAD_IO, 1'b0, 24'(rnd()), 8'h00, (8 << l) + 3, 1'b1);
        end
        // Frozen device must miss a whole wrap setup frame
        ce = 1'b0;
        i_host.start();
        i_host.send(32'(CMD_SET_WRAP), 8, 1);
        i_host.send(32'h0000_0010, 32, 1);
        i_host.stop();
        ce = 1'b1;
        `CHK("frozen wrap", wrap_s'({2'h3, 1'b0}), wrap_set)
        four = 1'b1;
        for (int p = 0; p < 4; p++)
        begin
            param = p[1:0];
            rd(CMD_QUAD_IO, 1'b0, 24'(rnd()) | 24'h00_003C, 8'h00, 12, 1'b1);
        end
        four = 1'b0;
        set_wrap(1'b1, 2'(rnd()));
        rd(CMD_QUAD_IO, 1'b0, 24'h12_34FC, 8'h00, 10, 1'b1);
        complete_run();
    end

    initial
    begin
        repeat (60000) @(posedge sys_clk);
        err_total++;
        complete_run();
    end
endmodule : serial_flash_multi_io_read_tb
